// *** rtl/acc_aux_converter_control.sv ***
// auxiliary dacs, contrast dac and shared signal/battery adc control
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - dsp write updates that dac code
// - contrast dac separate, 4-bit code
// - gain and freq dacs own enables
// - tx power dac follows transmit enable
// - contrast runs on low enable, upper nibble
// - contrast dac disabled after reset
// - full-scale field resets to 00
// - powered down dac output floats
// - range set only by field; 01 forbidden, code still stores 01 when written
// - shared adc, write selects source
// - write starts 20 us 8-bit conversion
// - result readable from both locations
// - completion sets conversion ready flag
// - result read clears ready flag
// - adc unpowered when conversion ends
// - power held until result latched
// - result kept after power down
module acc_aux_converter_control
   import acc_pkg::*;
#(
   parameter int unsigned CONV_CNT = CONV_CYCLES,
   parameter int unsigned IDLE_CNT = IDLE_CYCLES
) (
   input  wire logic        clk,              // 125 MHz clock
   input  wire logic        reset_n,          // sync reset, active low
   input  wire logic        gainWrite,        // dsp write strobe, gain dac
   input  wire logic        freqWrite,        // dsp write strobe, freq dac
   input  wire logic        txPowerWrite,     // dsp write strobe, tx power dac
   input  wire logic [7:0]  dspWriteData,     // dsp write data
   input  wire logic        gainEnable,       // mcu int control, gain dac enable
   input  wire logic        freqEnable,       // mcu int control, freq dac enable
   input  wire logic        transmitEnable,   // dsp status control tx enable
   input  wire logic        contrastWrite,    // mcu write strobe, contrast reg
   input  wire logic        fullScaleWrite,   // mcu write strobe, range field
   input  wire logic [7:0]  mcuWriteData,     // mcu write data
   input  wire logic        signalWrite,      // write to signal-strength loc
   input  wire logic        batteryWrite,     // write to battery loc
   input  wire logic        signalRead,       // read of signal-strength loc
   input  wire logic        batteryRead,      // read of battery loc
   input  wire logic        adcDone,          // analog converter sample valid
   input  wire logic [7:0]  adcSample,        // analog converter raw result
   output logic [7:0]       gainCode,         // gain dac code
   output logic             gainCodeOe,       // gain dac driving
   output logic [7:0]       freqCode,         // freq dac code
   output logic             freqCodeOe,       // freq dac driving
   output logic [7:0]       txPowerCode,      // tx power dac code
   output logic             txPowerCodeOe,    // tx power dac driving
   output logic [3:0]       contrastCode,     // contrast dac code
   output logic             contrastCodeOe,   // contrast dac driving
   output logic [1:0]       fullScaleSel,     // dac full-scale range
   output logic             adcPower,         // adc power on
   output logic             adcSource,        // 0 signal, 1 battery
   output logic             adcStart,         // pulse, start conversion
   output logic [7:0]       resultData,       // last conversion result
   output logic             conversionReady   // conversion ready flag
);

   typedef struct packed {
      logic [7:0]  gain;
      logic [7:0]  freq;
      logic [7:0]  txPower;
      logic [7:0]  contrast;
      logic [1:0]  fullScale;
      logic        source;
      logic        ready;
      logic [7:0]  result;
      logic        start;
      logic [31:0] count;
      acc_state_t  state;
   } acc_regs_t;

   acc_regs_t state_reg;
   acc_regs_t state_next;

   logic convWrite;
   logic resultRead;
   logic convDone;

   // counter has reached the last cycle of a span
   function automatic logic cnt_expired(input logic [31:0] cnt, input int unsigned limit);
      return cnt >= limit - 1;
   endfunction : cnt_expired

   assign convWrite  = signalWrite | batteryWrite;
   assign resultRead = signalRead | batteryRead;
   // conversion ends on a valid sample or on timeout
   assign convDone   = (state_reg.state == ACC_CONVERT)
                       && (adcDone || cnt_expired(state_reg.count, CONV_CNT));

   always_comb begin
      state_next = state_reg;
      state_next.start = 1'b0;
      if (gainWrite) begin
         state_next.gain = dspWriteData;
      end
      if (freqWrite) begin
         state_next.freq = dspWriteData;
      end
      if (txPowerWrite) begin
         state_next.txPower = dspWriteData;
      end
      if (contrastWrite) begin
         state_next.contrast = mcuWriteData;
      end
      if (fullScaleWrite) begin
         state_next.fullScale = 2'(mcuWriteData);
      end
      if (resultRead) begin
         state_next.ready = 1'b0;
      end
      case (state_reg.state)
         ACC_OFF, ACC_IDLE: begin
            if (state_reg.state == ACC_IDLE) begin
               if (cnt_expired(state_reg.count, IDLE_CNT)) begin
                  state_next.state = ACC_OFF;
                  state_next.count = '0;
               end else begin
                  state_next.count = state_reg.count + 32'h1;
               end
            end
         end
         ACC_CONVERT: begin
            if (convDone) begin
               state_next.result = adcSample;
               state_next.ready  = 1'b1;
               state_next.state  = ACC_IDLE;
               state_next.count  = '0;
            end else begin
               state_next.count = state_reg.count + 32'h1;
            end
         end
         default: begin
            state_next.state = ACC_OFF;
            state_next.count = '0;
         end
      endcase
      if (convWrite) begin
         state_next.source = batteryWrite ? SRC_BATTERY : SRC_SIGNAL;
         state_next.state  = ACC_CONVERT;
         state_next.count  = '0;
         state_next.start  = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_reg           <= '0;
         state_reg.gain      <= DAC_RESET;
         state_reg.freq      <= DAC_RESET;
         state_reg.txPower   <= DAC_RESET;
         state_reg.contrast  <= CON_RESET;
         state_reg.fullScale <= FS_RESET;
         state_reg.source    <= SRC_SIGNAL;
         state_reg.state     <= ACC_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   assign gainCode       = state_reg.gain;
   assign gainCodeOe     = gainEnable;
   assign freqCode       = state_reg.freq;
   assign freqCodeOe     = freqEnable;
   assign txPowerCode    = state_reg.txPower;
   assign txPowerCodeOe  = transmitEnable;
   assign contrastCode   = state_reg.contrast[CON_CODE_MSB:CON_CODE_LSB];
   assign contrastCodeOe = ~state_reg.contrast[CON_EN_N_BIT];
   assign fullScaleSel   = state_reg.fullScale;
   assign adcPower       = (state_reg.state == ACC_CONVERT);
   assign adcSource      = state_reg.source;
   assign adcStart       = state_reg.start;
   assign resultData     = state_reg.result;
   assign conversionReady = state_reg.ready;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   ready_set_a : assert property (
      (state_reg.state == ACC_CONVERT && adcDone && !convWrite) |=> conversionReady)
      else $error("ready not set on completion");

   ready_clear_a : assert property (
      (resultRead && !convDone) |=> !conversionReady)
      else $error("ready not cleared by read");

   result_latch_a : assert property (
      (state_reg.state == ACC_CONVERT && adcDone && !convWrite) |=> resultData == $past(adcSample))
      else $error("result not latched");

   power_on_a : assert property (
      convWrite |=> adcPower && adcStart)
      else $error("write did not power adc");

   power_off_a : assert property (
      (state_reg.state == ACC_CONVERT && adcDone && !convWrite) |=> !adcPower)
      else $error("adc kept powered");

   source_sel_a : assert property (
      (batteryWrite && !signalWrite) |=> adcSource == SRC_BATTERY)
      else $error("source not battery");

   result_hold_a : assert property (
      (!adcPower && !convWrite) |=> $stable(resultData))
      else $error("result changed while off");

   gain_upd_a : assert property (
      gainWrite |=> gainCode == $past(dspWriteData))
      else $error("gain code not updated");

   tx_en_a : assert property (
      txPowerCodeOe == transmitEnable)
      else $error("tx power enable mismatch");

   contrast_en_a : assert property (
      contrastWrite |=> contrastCodeOe == !$past(mcuWriteData[CON_EN_N_BIT]))
      else $error("contrast enable wrong");

   conv_time_a : assert property (
      (convWrite ##1 (!convWrite && !adcDone)[*8]) |-> adcPower)
      else $error("conversion ended early");

   freq_upd_a : assert property (
      freqWrite |=> freqCode == $past(dspWriteData))
      else $error("freq code not updated");

   txp_upd_a : assert property (
      txPowerWrite |=> txPowerCode == $past(dspWriteData))
      else $error("tx power code not updated");

   gain_hold_a : assert property (
      !gainWrite |=> $stable(gainCode))
      else $error("gain code changed without write");

   freq_hold_a : assert property (
      !freqWrite |=> $stable(freqCode))
      else $error("freq code changed without write");

   txp_hold_a : assert property (
      !txPowerWrite |=> $stable(txPowerCode))
      else $error("tx power code changed without write");

   contrast_code_a : assert property (
      contrastWrite |=> contrastCode == $past(mcuWriteData[CON_CODE_MSB:CON_CODE_LSB]))
      else $error("contrast code wrong");

   contrast_hold_a : assert property (
      !contrastWrite |=> $stable(contrastCode) && $stable(contrastCodeOe))
      else $error("contrast changed without write");

   dac_oe_a : assert property (
      gainCodeOe == gainEnable && freqCodeOe == freqEnable)
      else $error("dac enable mismatch");

   range_upd_a : assert property (
      fullScaleWrite |=> fullScaleSel == 2'($past(mcuWriteData)))
      else $error("range field not updated");

   range_hold_a : assert property (
      !fullScaleWrite |=> $stable(fullScaleSel))
      else $error("range changed without write");

   idle_off_a : assert property (
      (state_reg.state == ACC_IDLE && cnt_expired(state_reg.count, IDLE_CNT) && !convWrite)
      |=> state_reg.state == ACC_OFF)
      else $error("converter not powered off when idle");

   ready_hold_a : assert property (
      (conversionReady && !resultRead) |=> conversionReady)
      else $error("ready dropped without read");

   conv_restart_a : assert property (
      (adcPower && convWrite) |=> adcPower && adcStart && state_reg.count == '0)
      else $error("conversion not restarted");

   timeout_done_a : assert property (
      (state_reg.state == ACC_CONVERT && cnt_expired(state_reg.count, CONV_CNT) && !convWrite)
      |=> conversionReady && !adcPower)
      else $error("timeout did not complete");

   start_cause_a : assert property (
      adcStart |-> $past(convWrite))
      else $error("start without write");

   signal_sel_a : assert property (
      (signalWrite && !batteryWrite) |=> adcSource == SRC_SIGNAL)
      else $error("source not signal");

   cov_conv_c : cover property (convWrite ##[1:10] conversionReady);
   cov_restart_c : cover property (convWrite ##1 adcPower ##1 convWrite);
   cov_read_c : cover property (conversionReady ##1 resultRead);
   cov_off_c : cover property (adcPower ##1 !adcPower);
   cov_timeout_c : cover property (
      (state_reg.state == ACC_CONVERT && cnt_expired(state_reg.count, CONV_CNT)) ##1 conversionReady);

endmodule : acc_aux_converter_control

`default_nettype wire

// *** rtl/acc_pkg.sv ***
// constants for the auxiliary converter control block
package acc_pkg;
   localparam int unsigned CLK_MHZ        = 125;
   localparam int unsigned CONV_TIME_US   = 20;
   localparam int unsigned IDLE_TIME_US   = 40;
   localparam int unsigned CONV_CYCLES    = CONV_TIME_US * CLK_MHZ;
   localparam int unsigned IDLE_CYCLES    = IDLE_TIME_US * CLK_MHZ;
   localparam int unsigned DAC_WIDTH      = 8;
   localparam int unsigned CON_CODE_WIDTH = 4;
   localparam int unsigned CON_REG_WIDTH  = 8;
   localparam int unsigned CON_CODE_MSB   = 7;
   localparam int unsigned CON_CODE_LSB   = 4;
   localparam int unsigned CON_EN_N_BIT   = 0;
   localparam int unsigned ADC_WIDTH      = 8;
   localparam logic [1:0]  FS_RESET       = 2'h0;
   localparam logic [7:0]  DAC_RESET      = 8'h00;
   localparam logic [7:0]  CON_RESET      = 8'h01;
   localparam logic        SRC_SIGNAL     = 1'b0;
   localparam logic        SRC_BATTERY    = 1'b1;
   typedef enum logic [1:0] {ACC_OFF, ACC_CONVERT, ACC_IDLE} acc_state_t;
endpackage : acc_pkg

// *** dv/acc_adc_model.sv ***
// behavioural analog converter answering start pulses after a set delay
`timescale 1ns/10ps
`default_nettype none
module acc_adc_model (
   input  wire logic       clk,          // bench clock
   input  wire logic       adcStart,     // start pulse from the block
   input  wire logic [7:0] sampleVal,    // value to deliver
   input  wire logic [7:0] delayCycles,  // answer delay
   output logic            adcDone,      // sample valid
   output logic [7:0]      adcSample     // raw result
);
   logic       busy = 1'b0;
   logic [7:0] cnt;
   always_ff @(posedge clk) begin
      if (adcStart) begin
         busy <= 1'b1;
         cnt  <= delayCycles;
      end else if (busy && cnt == 8'h00) begin
         busy <= 1'b0;
      end else if (busy) begin
         cnt <= cnt - 8'h01;
      end
   end
   assign adcDone   = busy && cnt == 8'h00;
   // sample only valid with done, inverted otherwise
   assign adcSample = adcDone ? sampleVal : ~sampleVal;
endmodule : acc_adc_model
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking testbench for the auxiliary converter control block
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import acc_pkg::*;
;
   logic clk, reset_n, gainEnable, freqEnable, transmitEnable, adcDone;
   logic [8:0] stb;
   logic [7:0] dspData, mcuData, adcSample, sampleVal, delayCycles, gainCode, freqCode;
   logic [7:0] txPowerCode, resultData, d, con, en;
   logic [3:0] contrastCode;
   logic [1:0] fullScaleSel;
   logic gainCodeOe, freqCodeOe, txPowerCodeOe, contrastCodeOe, adcPower, adcSource;
   logic adcStart, conversionReady;
   int errors = 0, cmpCount = 0, seed = 92280, k;
   logic [1:0] fsTab [3] = '{2'h2, 2'h3, 2'h0};
   acc_aux_converter_control #(.CONV_CNT(20), .IDLE_CNT(40)) i_dut (.clk(clk),
      .reset_n(reset_n), .gainWrite(stb[0]), .freqWrite(stb[1]), .txPowerWrite(stb[2]),
      .dspWriteData(dspData), .gainEnable(gainEnable), .freqEnable(freqEnable),
      .transmitEnable(transmitEnable), .contrastWrite(stb[3]), .fullScaleWrite(stb[4]),
      .mcuWriteData(mcuData), .signalWrite(stb[5]), .batteryWrite(stb[6]),
      .signalRead(stb[7]), .batteryRead(stb[8]), .adcDone(adcDone), .adcSample(adcSample),
      .gainCode(gainCode), .gainCodeOe(gainCodeOe), .freqCode(freqCode),
      .freqCodeOe(freqCodeOe), .txPowerCode(txPowerCode), .txPowerCodeOe(txPowerCodeOe),
      .contrastCode(contrastCode), .contrastCodeOe(contrastCodeOe),
      .fullScaleSel(fullScaleSel), .adcPower(adcPower), .adcSource(adcSource),
      .adcStart(adcStart), .resultData(resultData), .conversionReady(conversionReady));
   acc_adc_model i_adc (.clk(clk), .adcStart(adcStart), .sampleVal(sampleVal),
      .delayCycles(delayCycles), .adcDone(adcDone), .adcSample(adcSample));
   function automatic logic [7:0] conExp(input logic [7:0] v);
      return {4'h0, v[7:4]};
   endfunction : conExp
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic pulse(input int n, input logic [7:0] v);
      @(posedge clk);
      #1;
      dspData = v;
      mcuData = v;
      stb[n] = 1'b1;
      @(posedge clk);
      #1;
      stb[n] = 1'b0;
   endtask : pulse
   task automatic conv(input int n, input logic [7:0] sv, input logic [7:0] dl,
                       input logic [7:0] exp);
      int w;
      sampleVal = sv;
      delayCycles = dl;
      pulse(n, 8'h00);
      chk("power on", adcPower, 8'h01);
      chk("source", adcSource, (n == 6) ? 8'h01 : 8'h00);
      w = 0;
      while (conversionReady !== 1'b1 && w < 300) begin
         @(posedge clk);
         #1;
         w++;
      end
      chk("ready", conversionReady, 8'h01);
      chk("result", resultData, exp);
      chk("power off", adcPower, 8'h00);
   endtask : conv
   task automatic close_out();
      $display("compares %0d mismatches %0d", cmpCount, errors);
      if (errors == 0 && cmpCount > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #100000;
      errors++;
      close_out();
   end
   initial begin
      {reset_n, gainEnable, freqEnable, transmitEnable, stb} = '0;
      {dspData, mcuData, sampleVal, delayCycles} = '0;
      repeat (8) @(posedge clk);
      #1 reset_n = 1'b1;
      chk("codes", gainCode | freqCode | txPowerCode, DAC_RESET);
      chk("oe", {gainCodeOe, freqCodeOe, txPowerCodeOe, contrastCodeOe}, 8'h00);
      chk("range", fullScaleSel, FS_RESET);
      chk("ready", {adcPower, conversionReady}, 8'h00);
      $display("test reset done");
      con = CON_RESET;
      for (int i = 0; i < 16; i++) begin
         d = (i < 4) ? 8'hFF : $random(seed);
         en = $random(seed);
         k = i % 4;
         {transmitEnable, freqEnable, gainEnable} = en[2:0];
         pulse(k, d);
         if (k == 3) con = d;
         chk("code", k == 0 ? gainCode : k == 1 ? freqCode : k == 2 ? txPowerCode
             : {contrastCode, 3'h0, ~contrastCodeOe}, (k == 3) ? (d & 8'hF1) : d);
         chk("contrast", {4'h0, contrastCode}, conExp(con));
         chk("oe", {contrastCodeOe, txPowerCodeOe, freqCodeOe, gainCodeOe},
             {~con[0], en[2:0]});
      end
      foreach (fsTab[j]) begin
         pulse(4, {6'h00, fsTab[j]});
         chk("range", fullScaleSel, fsTab[j]);
      end
      $display("test dacs done");
      conv(5, 8'h5A, 8'h00, 8'h5A);
      pulse(8, 8'h00);
      chk("ready clr", conversionReady, 8'h00);
      conv(6, 8'hA5, 8'h10, 8'hA5);
      repeat (50) @(posedge clk);
      chk("kept", resultData, 8'hA5);
      pulse(7, 8'h00);
      chk("ready clr", conversionReady, 8'h00);
      delayCycles = 8'h0A;
      pulse(6, 8'h00);
      conv(5, 8'h3C, 8'h0A, 8'h3C);
      pulse(8, 8'h00);
      d = $random(seed);
      conv(5, d, 8'hC8, ~d);
      $display("test converter done");
      close_out();
   end
endmodule : tb_top
`default_nettype wire
